//--- sps_slice.sv
// sps_slice: one-way stream port with selectable register mode and packing
// assumes: single clock; axi4-lite master holds each channel until taken
//
// Notes on behaviour
// R1 - data sign-extended to next whole byte
// R2 - each port carries one direction only
// R3 - default mode registers all handshake outputs
// R4 - forward mode registers data, valid only
// R5 - reverse mode registers only ready
// R6 - both mode registers data, valid, ready
// R7 - off mode passes everything combinationally; here beats still go through the fifo, one cycle accept to m_valid
// R8 - side channels registered exactly with data
// R9 - chained blocks need one registered side
// R10 - valid and ready always present
// R11 - optional side channels, sized widths
// R12 - no side channels: payload in data
// R13 - side channels kept separate beside data
// R14 - whole-stream packing merges all fields
// R15 - reset clears outputs, valid low
// R16 - transfer on valid and ready; hold
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "sps_regs.svh"
module sps_slice #(
  parameter int IN_W = 12, // raw data width before byte extension
  parameter int DEPTH = `SPS_FIFO_DEPTH // fifo depth
) (
  input wire logic clk, // 200 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic [IN_W-1:0] s_data, // upstream raw data
  input wire logic [3:0] s_keep, // upstream keep
  input wire logic [3:0] s_strb, // upstream strobe
  input wire logic [1:0] s_user, // upstream user
  input wire logic s_last, // upstream last
  input wire logic [4:0] s_id, // upstream id
  input wire logic [5:0] s_dest, // upstream dest
  input wire logic s_valid, // upstream valid
  output logic s_ready, // ready to upstream
  output logic [31:0] m_data, // downstream data (also driven in pack mode)
  output logic [3:0] m_keep, // downstream keep
  output logic [3:0] m_strb, // downstream strobe
  output logic [1:0] m_user, // downstream user
  output logic m_last, // downstream last
  output logic [4:0] m_id, // downstream id
  output logic [5:0] m_dest, // downstream dest
  output logic [53:0] m_wide, // whole-stream packed vector
  output logic m_valid, // downstream valid
  input wire logic m_ready, // downstream ready
  input wire sps_pkg::sps_axil_req_type axil_req, // axi4-lite request channels
  output sps_pkg::sps_axil_rsp_type axil_rsp // axi4-lite answer channels
);
  import sps_pkg::*;
  localparam int BYTE_W = ((IN_W + 7) / 8) * 8;
  localparam int BW = $bits(sps_beat_type);
  // register map, one aligned word each:
  //   ctrl 0x000: [1:0] mode (0 off, 1 fwd, 2 both, 3 rev), [2] pack all, [3] side channels
  //   stat 0x004: [0] out reg full, [1] s_ready, [2] m_valid, [7:3] fifo level
  //   cnt 0x008: beats delivered downstream
  //   any other word answers slverr with read data zero
  // accept to m_valid: one cycle in off and rev, two in fwd and both
  // control register
  logic [31:0] ctrl_q;
  sps_mode_type mode;
  logic pack_all;
  logic side_en;
  assign mode = sps_mode_type'(ctrl_q[`SPS_CTRL_MODE_LSB +: 2]);
  assign pack_all = ctrl_q[`SPS_CTRL_PACK_BIT];
  assign side_en = ctrl_q[`SPS_CTRL_SIDE_BIT];
  // input beat: sign extension and side channel gating
  sps_beat_type in_beat;
  logic [BYTE_W-1:0] ext_data;
  assign ext_data = {{(BYTE_W - IN_W){s_data[IN_W-1]}}, s_data}; // R1
  always_comb begin
    in_beat = '0;
    in_beat.data = 32'(signed'(ext_data)); // R1
    if (side_en) begin // R11 R13
      in_beat.keep = s_keep;
      in_beat.strb = s_strb;
      in_beat.user = s_user;
      in_beat.last = s_last;
      in_beat.id = s_id;
      in_beat.dest = s_dest;
    end
  end
  // fifo in the data path, feeding the register stage
  logic [BW-1:0] f_data;
  logic f_valid;
  logic f_take;
  logic [$clog2(DEPTH+1)-1:0] f_level;
  logic f_in_valid;
  logic f_in_ready;
  sps_fifo #(.WIDTH(BW), .DEPTH(DEPTH)) u_fifo ( // R2
    .clk(clk),
    .rst_n(rst_n),
    .in_data(in_beat),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_take),
    .level(f_level)
  );
  // reverse register: ready to upstream is a flop of fifo space
  logic rdy_q;
  logic reg_rdy;
  assign reg_rdy = (mode == SPS_MODE_REV) || (mode == SPS_MODE_BOTH); // R5 R6
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_q <= 1'b0; // R15
    end else begin
      // at least two free slots so an accept under stale ready never overflows
      rdy_q <= (f_level < ($clog2(DEPTH+1))'(DEPTH - 1)); // R5 R6
    end
  end
  assign s_ready = reg_rdy ? rdy_q : f_in_ready; // R4 R7 R10
  assign f_in_valid = s_valid && s_ready; // R16
  // forward register: data, side channels and valid flopped together
  logic reg_fwd;
  sps_beat_type out_q;
  logic vld_q;
  assign reg_fwd = (mode == SPS_MODE_FWD) || (mode == SPS_MODE_BOTH); // R4 R6
  assign f_take = reg_fwd ? (!vld_q || m_ready) : m_ready; // R16
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vld_q <= 1'b0; // R15
    end else if (!reg_fwd) begin
      vld_q <= 1'b0;
    end else if (!vld_q || m_ready) begin
      vld_q <= f_valid; // R4 R6
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '0; // R15
    end else if (reg_fwd && (!vld_q || m_ready) && f_valid) begin
      out_q <= f_data; // R8 R16
    end
  end
  // output selection: registered or straight from the fifo head
  sps_beat_type out_beat;
  assign out_beat = reg_fwd ? out_q : sps_beat_type'(f_data); // R7 R8
  assign m_valid = reg_fwd ? vld_q : f_valid; // R10
  always_comb begin
    m_data = out_beat.data; // R12
    m_keep = out_beat.keep; // R13
    m_strb = out_beat.strb;
    m_user = out_beat.user;
    m_last = out_beat.last;
    m_id = out_beat.id;
    m_dest = out_beat.dest;
    m_wide = '0;
    if (pack_all) begin
      m_wide = out_beat; // R14
      m_keep = '0;
      m_strb = '0;
      m_user = '0;
      m_last = 1'b0;
      m_id = '0;
      m_dest = '0;
    end
  end
  // beat counter, read back over the bus
  logic [31:0] beats_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beats_q <= '0;
    end else if (m_valid && m_ready) begin
      beats_q <= beats_q + 32'h0000_0001; // R16
    end
  end
  // axi4-lite write: address and data taken in either order
  logic aw_hold_q;
  logic w_hold_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic [11:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  assign aw_take = axil_req.awvalid && !aw_hold_q && !bvalid_q;
  assign w_take = axil_req.wvalid && !w_hold_q && !bvalid_q;
  assign wr_go = (aw_hold_q || aw_take) && (w_hold_q || w_take);
  assign wa = aw_hold_q ? awaddr_q : axil_req.awaddr[11:0];
  assign wd = w_hold_q ? wdata_q : axil_req.wdata;
  assign ws = w_hold_q ? wstrb_q : axil_req.wstrb;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wr_go) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= axil_req.awaddr[11:0];
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        wdata_q <= axil_req.wdata;
        wstrb_q <= axil_req.wstrb;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= ({wa[11:2], 2'h0} == `SPS_CTRL_OFFSET) ? 2'h0 : 2'h2;
    end else if (axil_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end
  // a control write waits until nothing is in flight: switching the output
  // stage under a stalled beat would drop it or move its side channels
  logic wr_ctrl;
  logic pipe_idle;
  logic ctrl_pend_q;
  logic [3:0] ctrl_new_q;
  assign wr_ctrl = ({wa[11:2], 2'h0} == `SPS_CTRL_OFFSET);
  assign pipe_idle = !f_valid && !vld_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_pend_q <= 1'b0;
      ctrl_new_q <= 4'h0;
    end else if (wr_go && wr_ctrl && ws[0]) begin
      ctrl_pend_q <= 1'b1;
      ctrl_new_q <= wd[3:0];
    end else if (pipe_idle) begin
      ctrl_pend_q <= 1'b0;
    end
  end
  // limitation: a stream that never drains keeps the new mode pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `SPS_CTRL_RESET; // R3 R6
    end else if (ctrl_pend_q && pipe_idle) begin
      ctrl_q <= {28'h0, ctrl_new_q}; // R8
    end
  end
  // axi4-lite read
  sps_rd_state_type rd_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [11:0] ra;
  assign ra = {axil_req.araddr[11:2], 2'h0};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= SPS_RD_IDLE;
      rdata_q <= '0;
      rresp_q <= 2'h0;
    end else begin
      case (rd_q)
        SPS_RD_IDLE: begin
          if (axil_req.arvalid) begin
            rd_q <= SPS_RD_RESP;
            rresp_q <= 2'h0;
            case (ra)
              `SPS_CTRL_OFFSET: rdata_q <= ctrl_q;
              `SPS_STAT_OFFSET: rdata_q <= {24'h0, 5'(f_level), m_valid, s_ready, vld_q};
              `SPS_CNT_OFFSET: rdata_q <= beats_q;
              default: begin
                rdata_q <= '0;
                rresp_q <= 2'h2;
              end
            endcase
          end
        end
        SPS_RD_RESP: begin
          if (axil_req.rready) begin
            rd_q <= SPS_RD_IDLE;
          end
        end
        default: begin
          rd_q <= SPS_RD_IDLE;
        end
      endcase
    end
  end
  always_comb begin
    axil_rsp = '0;
    axil_rsp.awready = !aw_hold_q && !bvalid_q;
    axil_rsp.wready = !w_hold_q && !bvalid_q;
    axil_rsp.bvalid = bvalid_q;
    axil_rsp.bresp = bresp_q;
    axil_rsp.arready = (rd_q == SPS_RD_IDLE);
    axil_rsp.rvalid = (rd_q == SPS_RD_RESP);
    axil_rsp.rdata = rdata_q;
    axil_rsp.rresp = rresp_q;
  end
endmodule : sps_slice

//--- sps_regs.svh
// sps_regs.svh: register offsets, field positions, reset values and mode codes for the stream port
// assumes: included by its bare name from the package and the design modules
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH
`define SPS_CTRL_OFFSET 12'h000
`define SPS_STAT_OFFSET 12'h004
`define SPS_CNT_OFFSET 12'h008
`define SPS_CTRL_MODE_LSB 0
`define SPS_CTRL_PACK_BIT 2
`define SPS_CTRL_SIDE_BIT 3
`define SPS_CTRL_RESET 32'h0000_000A
`define SPS_MODE_BOTH 2'h2
`define SPS_FIFO_DEPTH 4
`endif

//--- sps_pkg.sv
// sps_pkg: types shared by the stream port slice and its fifo
// assumes: sps_regs.svh is on the include path
`include "sps_regs.svh"
package sps_pkg;
  typedef enum logic [1:0] {
    SPS_MODE_OFF = 2'h0,
    SPS_MODE_FWD = 2'h1,
    SPS_MODE_BOTH = 2'h2,
    SPS_MODE_REV = 2'h3
  } sps_mode_type;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] keep;
    logic [3:0] strb;
    logic [1:0] user;
    logic last;
    logic [4:0] id;
    logic [5:0] dest;
  } sps_beat_type;
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } sps_axil_req_type;
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } sps_axil_rsp_type;
  typedef enum logic [2:0] {
    SPS_RD_IDLE = 3'b001,
    SPS_RD_RESP = 3'b010,
    SPS_RD_HOLD = 3'b100
  } sps_rd_state_type;
endpackage : sps_pkg

//--- sps_fifo.sv
// sps_fifo: small flip-flop fifo with valid/ready on both sides
// assumes: one clock, asynchronous active-low reset
`timescale 1ns/1ps
module sps_fifo #(
  parameter int WIDTH = 54,
  parameter int DEPTH = 4
) (
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] in_data, // write data
  input wire logic in_valid, // write valid
  output logic in_ready, // not full
  output logic [WIDTH-1:0] out_data, // head entry
  output logic out_valid, // not empty
  input wire logic out_ready, // reader takes head
  output logic [$clog2(DEPTH+1)-1:0] level // entries held
);
  import sps_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [$clog2(DEPTH+1)-1:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rp_q];
  assign level = cnt_q;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_q[g] <= '0;
        end else if (push && wp_q == AW'(g)) begin
          mem_q[g] <= in_data;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : sps_fifo

//--- sps_slice_chk.sv
// sps_slice_chk: concurrent checks on the stream port slice ports
// assumes: bound to sps_slice; single clock, async active-low reset
`timescale 1ns/1ps
module sps_slice_chk #(
  parameter int IN_W = 12 // raw data width
) (
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic s_valid, // upstream valid
  input wire logic s_ready, // ready to upstream
  input wire logic [31:0] m_data, // downstream data
  input wire logic [3:0] m_keep, // downstream keep
  input wire logic [53:0] m_wide, // packed vector
  input wire logic m_valid, // downstream valid
  input wire logic m_ready, // downstream ready
  input wire sps_pkg::sps_axil_req_type axil_req, // axi4-lite requests
  input wire sps_pkg::sps_axil_rsp_type axil_rsp // axi4-lite answers
);
  import sps_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_valid_hold: assert property (m_valid && !m_ready |=> m_valid && $stable(m_data))
    else $error("stalled beat dropped or changed");
  chk_side_hold: assert property (m_valid && !m_ready |=> $stable({m_keep, m_wide}))
    else $error("side channels moved while stalled");
  chk_reset_clear: assert property ($rose(rst_n) |-> !m_valid && !s_ready && !axil_rsp.bvalid)
    else $error("outputs not cleared by reset");
  chk_sign_extend: assert property (m_valid && m_wide == '0 |->
    (&m_data[31:IN_W-1]) || !(|m_data[31:IN_W-1]))
    else $error("data not sign extended");
  chk_accept_out: assert property (s_valid && s_ready |-> ##[1:3] m_valid)
    else $error("accepted beat never offered");
  chk_pack_side: assert property (m_wide != '0 |-> m_keep == 4'h0)
    else $error("side port active while packed");
  chk_write_busy: assert property (axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready)
    else $error("write taken while response pending");
  chk_read_busy: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
    else $error("read taken while data pending");
  chk_write_answer: assert property (axil_req.awvalid && axil_rsp.awready &&
    axil_req.wvalid && axil_rsp.wready |=> axil_rsp.bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
    else $error("read data missing");
endmodule : sps_slice_chk

//--- sps_sink.sv
// sps_sink: downstream stream block model, ready on command of the bench
// assumes: bench raises stall to apply back-pressure
`timescale 1ns/1ps
module sps_sink (
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic stall, // back-pressure request
  output logic m_ready // ready back to the slice
);
  // ready from a flop, so chaining never closes a combinational loop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) m_ready <= 1'h0;
    else m_ready <= !stall;
  end
endmodule : sps_sink

//--- sps_slice_bench.sv
// sps_slice_bench: self-checking bench for the stream port slice
// assumes: sps_sink and sps_slice_chk compiled before it
`timescale 1ns/1ps
module sps_slice_bench;
  import sps_pkg::*;
  logic clk, rst_n, s_valid, s_last, stall, s_ready, m_valid, m_ready, m_last;
  logic [11:0] s_data;
  logic [3:0] s_keep, s_strb, m_keep, m_strb;
  logic [1:0] s_user, m_user;
  logic [4:0] s_id, m_id;
  logic [5:0] s_dest, m_dest;
  logic [31:0] m_data;
  logic [53:0] m_wide;
  sps_axil_req_type axil_req;
  sps_axil_rsp_type axil_rsp;
  logic [35:0] rx[$];
  int miscompares, comparisons, tot;
  sps_slice #(.IN_W(12)) uut (.clk, .rst_n, .s_data, .s_keep, .s_strb, .s_user, .s_last,
    .s_id, .s_dest, .s_valid, .s_ready, .m_data, .m_keep, .m_strb, .m_user, .m_last,
    .m_id, .m_dest, .m_wide, .m_valid, .m_ready, .axil_req, .axil_rsp);
  sps_sink sink (.clk, .rst_n, .stall, .m_ready);
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (rst_n && m_valid === 1'h1 && m_ready === 1'h1) begin
    rx.push_back({m_keep, m_data});
    tot++;
  end
  task automatic check(input string nm, input logic [63:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    axil_req.awaddr <= a;
    axil_req.wdata <= d;
    axil_req.wstrb <= 4'hF;
    axil_req.awvalid <= 1'h1;
    axil_req.wvalid <= 1'h1;
    axil_req.bready <= 1'h1;
    do begin
      @(posedge clk);
      if (axil_rsp.awready === 1'h1) axil_req.awvalid <= 1'h0;
      if (axil_rsp.wready === 1'h1) axil_req.wvalid <= 1'h0;
    end while (axil_rsp.bvalid !== 1'h1);
    axil_req.bready <= 1'h0;
    check("bresp", axil_rsp.bresp, er);
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
    axil_req.araddr <= a;
    axil_req.arvalid <= 1'h1;
    axil_req.rready <= 1'h1;
    do begin
      @(posedge clk);
      if (axil_rsp.arready === 1'h1) axil_req.arvalid <= 1'h0;
    end while (axil_rsp.rvalid !== 1'h1);
    axil_req.rready <= 1'h0;
    check("rdata", axil_rsp.rdata, ed);
    check("rresp", axil_rsp.rresp, er);
    @(posedge clk);
  endtask : rd
  // valid stays up across beats so back-to-back sends never glitch it
  task automatic burst(input int n, input logic [11:0] b);
    for (int i = 0; i < n; i++) begin
      s_data <= b + 12'(i);
      s_valid <= 1'h1;
      do @(posedge clk); while (s_ready !== 1'h1);
    end
    s_valid <= 1'h0;
  endtask : burst
  task automatic expect_rx(input int n, input logic [11:0] b, input logic [3:0] k);
    logic [11:0] v;
    repeat (40) if (rx.size() < n) @(posedge clk);
    check("beats", rx.size(), n);
    for (int i = 0; i < n; i++) begin
      v = b + 12'(i);
      check("beat", rx[i], {k, {20{v[11]}}, v});
    end
    rx.delete();
  endtask : expect_rx
  task automatic t_reset;
    check("valid", m_valid, 1'h0);
    rd(32'h0, 32'hA, 2'h0);
    rd(32'hC, 32'h0, 2'h2);
    wr(32'hC, 32'h0, 2'h2);
    $display("test reset done");
  endtask : t_reset
  task automatic t_modes;
    int lat;
    for (int m = 0; m < 4; m++) begin
      wr(32'h0, 32'h8 | m, 2'h0);
      s_keep <= 4'h5 + 4'(m);
      burst(1, 12'h800 + 12'(m));
      lat = 0;
      #1;
      while (m_valid !== 1'h1 && lat < 8) begin
        @(posedge clk);
        #1;
        lat++;
      end
      check("latency", lat, (m == 0 || m == 3) ? 0 : 1);
      expect_rx(1, 12'h800 + 12'(m), 4'h5 + 4'(m));
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_pack;
    wr(32'h0, 32'hE, 2'h0);
    {s_keep, s_strb, s_user, s_last, s_id, s_dest} <= 22'h35_A5C3;
    burst(1, 12'h9A5);
    repeat (40) if (m_valid !== 1'h1) @(posedge clk);
    check("wide", m_wide, {32'hFFFF_F9A5, 22'h35_A5C3});
    check("keep", m_keep, 4'h0);
    check("side off", {m_strb, m_user, m_last, m_id, m_dest}, 18'h0);
    @(posedge clk);
    rx.delete();
    wr(32'h0, 32'h2, 2'h0);
    burst(3, 12'h7FE);
    expect_rx(3, 12'h7FE, 4'h0);
    $display("test pack done");
  endtask : t_pack
  task automatic t_fill;
    int n;
    wr(32'h0, 32'hA, 2'h0);
    stall <= 1'h1;
    repeat (2) @(posedge clk);
    n = 0;
    s_valid <= 1'h1;
    s_data <= 12'hF00;
    repeat (12) begin
      @(posedge clk);
      if (s_ready === 1'h1) begin
        n++;
        s_data <= 12'hF00 + 12'(n);
      end
    end
    s_valid <= 1'h0;
    check("refused", n > 3 && n < 8, 1'h1);
    check("held", rx.size(), 0);
    check("side", {m_keep, m_strb, m_user, m_last, m_id, m_dest}, 22'h35_A5C3);
    check("wide off", m_wide, 54'h0);
    rd(32'h4, 32'h25, 2'h0);
    stall <= 1'h0;
    expect_rx(n, 12'hF00, 4'hD);
    rd(32'h8, tot, 2'h0);
    $display("test fill done");
  endtask : t_fill
  initial begin
    rst_n = 1'h0;
    s_valid = 1'h0;
    s_data = 12'h0;
    {s_keep, s_strb, s_user, s_last, s_id, s_dest} = 22'h0;
    stall = 1'h0;
    axil_req = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_reset;
    t_modes;
    t_pack;
    t_fill;
    conclude;
  end
  initial begin
    #50000;
    miscompares++;
    conclude;
  end
endmodule : sps_slice_bench
bind sps_slice sps_slice_chk #(.IN_W(IN_W)) chk (.clk, .rst_n, .s_valid, .s_ready, .m_data,
  .m_keep, .m_wide, .m_valid, .m_ready, .axil_req, .axil_rsp);
